// ===== core/irxc_ctrl.sv
/*
 Control and status for four isochronous receive DMA contexts.
 Assumes a packet/descriptor engine outside that answers fetch requests
 and reports fatal errors, completions and cycle matches per context.
*/
`timescale 1ns/10ps
module irxc_ctrl #(
	parameter int unsigned NCTX = irxc_pkg::NCTX
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic soft_reset,
	input wire logic [11:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [1:0] avs_response,
	output logic [NCTX-1:0] fetch_req,
	output logic [NCTX-1:0] [31:0] fetch_addr,
	output logic [NCTX-1:0] packed_fill_mode,
	output logic [NCTX-1:0] backout,
	input wire logic [NCTX-1:0] fetch_done,
	input wire logic [NCTX-1:0] ctx_idle,
	input wire logic [NCTX-1:0] fatal_err,
	input wire logic [NCTX-1:0] cycle_match,
	input wire irxc_pkg::irxc_done_t [NCTX-1:0] done,
	output logic irq
);
	irxc_pkg::irxc_state_t st_r [NCTX];
	irxc_pkg::irxc_state_t st_nxt [NCTX];
	logic [NCTX-1:0] [31:0] ctl_r;
	logic [NCTX-1:0] [31:0] ptr_r;
	logic [NCTX-1:0] fetch_r;
	logic [NCTX-1:0] backout_r;
	logic [2*NCTX-1:0] stat_r;
	logic [2*NCTX-1:0] en_r;
	logic [31:0] rdata_r;
	logic [1:0] resp_r;
	logic wait_r;
	logic irq_r;

	// Reply one cycle after the request: waitrequest drops in the answer cycle
	wire req = (avs_read | avs_write) & wait_r;
	wire wr = avs_write & wait_r;
	wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	wire [31:0] wmask = avs_writedata & be_mask;

	function automatic logic [11:0] ctx_off(input logic [11:0] base, input int unsigned n);
		ctx_off = base + 12'(n * 32);
	endfunction

	// Completion code chosen by mode; packed fill only uses four codes
	function automatic logic [4:0] evt_code(input irxc_pkg::irxc_done_t d, input logic fill);
		logic [4:0] c;
		c = irxc_pkg::EVT_ACK_COMPLETE;
		if (d.desc_rd_err) begin
			c = irxc_pkg::EVT_DESC_RD;
		end else if (d.data_wr_err) begin
			c = irxc_pkg::EVT_DATA_WR;
		end else if (d.unk_err) begin
			c = irxc_pkg::EVT_UNKNOWN;
		end else if (!fill) begin
			if (d.overrun) begin
				c = irxc_pkg::EVT_OVERRUN;
			end else if (d.long_pkt) begin
				c = irxc_pkg::EVT_LONG_PKT;
			end else if (d.len_err | d.crc_err) begin
				c = irxc_pkg::EVT_ACK_DATA_ERR;
			end
		end
		evt_code = c;
	endfunction

	logic [31:0] rd_mux;
	logic hit;
	always_comb begin
		rd_mux = 32'h0000_0000;
		hit = 1'b0;
		for (int unsigned n = 0; n < NCTX; n++) begin
			if (avs_address == ctx_off(irxc_pkg::CTRL_SET_BASE, n) ||
				avs_address == ctx_off(irxc_pkg::CTRL_CLR_BASE, n)) begin
				rd_mux = ctl_r[n] & irxc_pkg::CTRL_RD_MASK;
				hit = 1'b1;
			end
			if (avs_address == ctx_off(irxc_pkg::PTR_BASE, n)) begin
				rd_mux = ptr_r[n];
				hit = 1'b1;
			end
			if (avs_address == ctx_off(irxc_pkg::PTR_WR_BASE, n)) begin
				rd_mux = 32'h0000_0000;
				hit = 1'b1;
			end
		end
		if (avs_address == irxc_pkg::IRQ_STAT) begin
			rd_mux = 32'(stat_r);
			hit = 1'b1;
		end
		if (avs_address == irxc_pkg::IRQ_CLR) begin
			hit = 1'b1;
		end
		if (avs_address == irxc_pkg::IRQ_EN) begin
			rd_mux = 32'(en_r);
			hit = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_r <= 1'b1;
			rdata_r <= 32'h0000_0000;
			resp_r <= 2'h0;
		end else begin
			wait_r <= ~req;
			rdata_r <= (req & avs_read) ? rd_mux : 32'h0000_0000;
			resp_r <= (req & ~hit) ? 2'h2 : 2'h0;
		end
	end

	generate
		for (genvar n = 0; n < NCTX; n++) begin : g_ctx
			wire set_hit = wr && avs_address == ctx_off(irxc_pkg::CTRL_SET_BASE, n);
			wire clr_hit = wr && avs_address == ctx_off(irxc_pkg::CTRL_CLR_BASE, n);
			wire ptr_hit = wr && avs_address == ctx_off(irxc_pkg::PTR_WR_BASE, n);
			wire [31:0] setv = set_hit ? (wmask & irxc_pkg::CTRL_SW_MASK) : 32'h0000_0000;
			wire [31:0] clrv = clr_hit ? (wmask & irxc_pkg::CTRL_SW_MASK) : 32'h0000_0000;
			wire [31:0] sw_ctl = (ctl_r[n] | setv) & ~clrv;
			wire run = sw_ctl[irxc_pkg::B_RUN];
			wire run_old = ctl_r[n][irxc_pkg::B_RUN];
			wire wake_set = setv[irxc_pkg::B_WAKE];
			wire fill = ctl_r[n][irxc_pkg::B_FILL];
			wire processing = st_r[n] == irxc_pkg::IRXC_FETCH || st_r[n] == irxc_pkg::IRXC_RUN;
			logic [31:0] ctl_nxt;

			always_comb begin
				st_nxt[n] = st_r[n];
				unique case (st_r[n])
					irxc_pkg::IRXC_IDLE: begin
						if (run && (!run_old || wake_set || ctl_r[n][irxc_pkg::B_WAKE])) begin
							st_nxt[n] = irxc_pkg::IRXC_FETCH;
						end
					end
					irxc_pkg::IRXC_FETCH: begin
						if (fetch_done[n]) begin
							st_nxt[n] = irxc_pkg::IRXC_RUN;
						end
					end
					irxc_pkg::IRXC_RUN: begin
						if (ctx_idle[n]) begin
							st_nxt[n] = irxc_pkg::IRXC_IDLE;
						end
					end
					irxc_pkg::IRXC_HALT: begin
						st_nxt[n] = irxc_pkg::IRXC_HALT;
					end
				endcase
				if (processing && fatal_err[n]) begin
					st_nxt[n] = irxc_pkg::IRXC_HALT;
				end
				if (!run) begin
					st_nxt[n] = irxc_pkg::IRXC_IDLE;
				end
			end

			always_comb begin
				ctl_nxt = sw_ctl;
				// fetch clears wake; set wins over clear
				if (fetch_done[n] && st_r[n] == irxc_pkg::IRXC_FETCH && !wake_set) begin
					ctl_nxt[irxc_pkg::B_WAKE] = 1'b0;
				end
				ctl_nxt[irxc_pkg::B_DEAD] = run && (st_nxt[n] == irxc_pkg::IRXC_HALT);
				ctl_nxt[irxc_pkg::B_ACT] = st_nxt[n] == irxc_pkg::IRXC_FETCH ||
					st_nxt[n] == irxc_pkg::IRXC_RUN;
				if (cycle_match[n] && ctl_r[n][irxc_pkg::B_CSG] && st_nxt[n] != irxc_pkg::IRXC_IDLE) begin
					ctl_nxt[irxc_pkg::B_CSG] = 1'b0;
				end
				if (done[n].valid) begin
					ctl_nxt[irxc_pkg::B_SPD_LO +: 3] = done[n].spd;
					ctl_nxt[4:0] = evt_code(done[n], fill);
				end
			end

			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					ctl_r[n] <= 32'h0000_0000;
					st_r[n] <= irxc_pkg::IRXC_IDLE;
					ptr_r[n] <= 32'h0000_0000;
					fetch_r[n] <= 1'b0;
					backout_r[n] <= 1'b0;
				end else if (soft_reset) begin
					ctl_r[n] <= 32'h0000_0000;
					st_r[n] <= irxc_pkg::IRXC_IDLE;
					fetch_r[n] <= 1'b0;
					backout_r[n] <= 1'b0;
				end else begin
					ctl_r[n] <= ctl_nxt;
					st_r[n] <= st_nxt[n];
					if (ptr_hit) begin
						ptr_r[n] <= wmask;
					end
					fetch_r[n] <= st_nxt[n] == irxc_pkg::IRXC_FETCH;
					backout_r[n] <= done[n].valid && fill &&
						(done[n].len_err | done[n].crc_err | done[n].overrun);
				end
			end

			assign fetch_addr[n] = ptr_r[n];
			assign packed_fill_mode[n] = ctl_r[n][irxc_pkg::B_FILL];
		end
	endgenerate

	// Events: bit n = context halted, bit NCTX+n = completion
	logic [2*NCTX-1:0] ev;
	always_comb begin
		for (int unsigned n = 0; n < NCTX; n++) begin
			// Dead and state move on the same edge, so the halt entry itself is the event
			ev[n] = st_nxt[n] == irxc_pkg::IRXC_HALT && st_r[n] != irxc_pkg::IRXC_HALT;
			ev[NCTX+n] = done[n].valid;
		end
	end
	wire clr_w = wr && avs_address == irxc_pkg::IRQ_CLR;
	wire en_w = wr && avs_address == irxc_pkg::IRQ_EN;
	wire [2*NCTX-1:0] clr_bits = clr_w ? wmask[2*NCTX-1:0] : '0;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stat_r <= '0;
			en_r <= '0;
			irq_r <= 1'b0;
		end else begin
			stat_r <= (stat_r & ~clr_bits) | ev;
			if (en_w) begin
				en_r <= wmask[2*NCTX-1:0];
			end
			irq_r <= |(((stat_r & ~clr_bits) | ev) & (en_w ? wmask[2*NCTX-1:0] : en_r));
		end
	end

	assign avs_readdata = rdata_r;
	assign avs_waitrequest = wait_r;
	assign avs_response = resp_r;
	assign fetch_req = fetch_r;
	assign backout = backout_r;
	assign irq = irq_r;
endmodule

// ===== core/irxc_pkg.sv
/*
 Package for the isochronous receive context control block: register map,
 control field positions, speed and completion codes, completion report struct.
 Assumes a 32-bit Avalon-MM slave with byte addresses.
*/
package irxc_pkg;
	localparam int unsigned NCTX = 4;
	localparam logic [11:0] CTRL_SET_BASE = 12'h400;
	localparam logic [11:0] CTRL_CLR_BASE = 12'h404;
	localparam logic [11:0] PTR_BASE = 12'h40C;
	localparam logic [11:0] CTX_STRIDE = 12'h020;
	localparam logic [11:0] PTR_WR_BASE = 12'h418;
	localparam logic [11:0] IRQ_STAT = 12'h480;
	localparam logic [11:0] IRQ_CLR = 12'h484;
	localparam logic [11:0] IRQ_EN = 12'h488;
	localparam int unsigned B_FILL = 31;
	localparam int unsigned B_CSG = 29;
	localparam int unsigned B_RUN = 15;
	localparam int unsigned B_WAKE = 12;
	localparam int unsigned B_DEAD = 11;
	localparam int unsigned B_ACT = 10;
	localparam int unsigned B_SPD_LO = 5;
	localparam logic [31:0] CTRL_RD_MASK = 32'hF800_9CFF;
	localparam logic [31:0] CTRL_SW_MASK = 32'hF800_9000;
	localparam logic [2:0] SPD_S100 = 3'h0;
	localparam logic [2:0] SPD_S200 = 3'h1;
	localparam logic [2:0] SPD_S400 = 3'h2;
	localparam logic [4:0] EVT_ACK_COMPLETE = 5'h11;
	localparam logic [4:0] EVT_ACK_DATA_ERR = 5'h1D;
	localparam logic [4:0] EVT_LONG_PKT = 5'h02;
	localparam logic [4:0] EVT_OVERRUN = 5'h05;
	localparam logic [4:0] EVT_DESC_RD = 5'h06;
	localparam logic [4:0] EVT_DATA_WR = 5'h07;
	localparam logic [4:0] EVT_UNKNOWN = 5'h0E;
	// Per-context completion report from the packet engine
	typedef struct packed {
		logic valid;
		logic [2:0] spd;
		logic len_err;
		logic crc_err;
		logic overrun;
		logic long_pkt;
		logic desc_rd_err;
		logic data_wr_err;
		logic unk_err;
	} irxc_done_t;
	typedef enum logic [1:0] {
		IRXC_IDLE = 2'b00,
		IRXC_FETCH = 2'b01,
		IRXC_RUN = 2'b10,
		IRXC_HALT = 2'b11
	} irxc_state_t;
endpackage

// ===== verification/irxc_ctrl_bench.sv
/* Self-checking bench for irxc_ctrl.
 Assumes irxc_engine answers fetches and irxc_props is bound. */
`timescale 1ns/10ps
module irxc_ctrl_bench;
	logic clk = 0, rst_n = 0, soft_reset = 0, avs_read = 0, avs_write = 0, xirq = 0;
	logic avs_waitrequest, irq;
	logic [1:0] avs_response;
	logic [2:0] s;
	logic [3:0] avs_byteenable = 4'hF, ctx_idle = '0, fatal_err = '0, cycle_match = '0;
	logic [3:0] lat = 4'hC, fetch_req, fetch_done, packed_fill_mode, backout, fr_r = '0;
	logic [11:0] avs_address = '0, sb, cb;
	logic [31:0] avs_writedata = '0, avs_readdata, cm = 32'h07FF_FFFF;
	logic [3:0][31:0] fetch_addr, pv;
	irxc_pkg::irxc_done_t [3:0] done = '0;
	logic [4:0] ev[8] = '{5'h1D, 5'h1D, 5'h05, 5'h02, 5'h06, 5'h07, 5'h0E, 5'h11};
	logic [34:0] eq[$];
	logic [31:0] mq[$], fq[$];
	int num_errors = 0, total_checks = 0, seed = 32'h48270FE7;
	irxc_ctrl DUT (.clk, .rst_n, .soft_reset, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response,
		.fetch_req, .fetch_addr, .packed_fill_mode, .backout, .fetch_done, .ctx_idle,
		.fatal_err, .cycle_match, .done, .irq);
	irxc_engine mem (.clk, .rst_n, .lat, .fetch_req, .fetch_done);
	always #20 clk = ~clk;
	task chk(input logic [34:0] seen, input logic [34:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task bus(input logic w, input logic [11:0] a, input logic [31:0] v);
		@(posedge clk);
		avs_write <= w;
		avs_read <= !w;
		avs_address <= a;
		avs_writedata <= v;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] v, input logic [1:0] r = 0);
		mq.push_back(m);
		eq.push_back({xirq, r, v & m});
		bus(1'b0, a, '0);
	endtask
	task fetched(input int n);
		@(posedge clk iff fetch_done[n]);
		repeat (2) @(posedge clk);
	endtask
	function logic [11:0] ad(input logic [11:0] b, input int n);
		return b + 12'(n * 32);
	endfunction
	task complete_run;
		if (num_errors == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		if (avs_read && avs_waitrequest === 1'b0) begin
			chk({irq, avs_response, avs_readdata & mq.pop_front()}, eq.pop_front());
		end
		for (int i = 0; i < 4; i++) begin
			if (fetch_req[i] && !fr_r[i]) chk(35'(fetch_addr[i]), 35'(fq.pop_front()));
		end
		fr_r <= fetch_req;
	end
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		// Context 3 halt stays masked from irq
		bus(1'b1, irxc_pkg::IRQ_EN, 32'h7);
		rd(12'h0F0, '1, '0, 2'h2);
		for (int n = 0; n < 4; n++) begin
			sb = ad(irxc_pkg::CTRL_SET_BASE, n);
			cb = ad(irxc_pkg::CTRL_CLR_BASE, n);
			pv[n] = $random(seed);
			bus(1'b1, ad(irxc_pkg::PTR_WR_BASE, n), pv[n]);
			bus(1'b1, ad(irxc_pkg::PTR_BASE, n), ~pv[n]);
			rd(ad(irxc_pkg::PTR_BASE, n), '1, pv[n]);
			fq.push_back(pv[n]);
			bus(1'b1, sb, ($random(seed) & 32'h4000_0000) | 32'h9000);
			repeat (2) @(posedge clk);
			rd(cb, cm, 32'h9400);
			fetched(n);
			rd(sb, cm, 32'h8400);
			fatal_err[n] <= 1'b1;
			@(posedge clk);
			fatal_err[n] <= 1'b0;
			xirq = n < 3;
			repeat (2) @(posedge clk);
			rd(sb, cm, 32'h8800);
			rd(irxc_pkg::IRQ_STAT, 32'hF, 32'h1 << n);
			bus(1'b1, cb, 32'h8000);
			rd(sb, cm, '0);
			bus(1'b1, irxc_pkg::IRQ_CLR, 32'hF);
			xirq = 0;
			rd(irxc_pkg::IRQ_STAT, 32'hF, '0);
		end
		lat <= 4'h0;
		fq.push_back(pv[0]);
		bus(1'b1, irxc_pkg::CTRL_SET_BASE, 32'h8000);
		fetched(0);
		ctx_idle[0] <= 1'b1;
		@(posedge clk);
		ctx_idle[0] <= 1'b0;
		repeat (2) @(posedge clk);
		rd(irxc_pkg::CTRL_SET_BASE, cm, 32'h8000);
		fq.push_back(pv[0]);
		bus(1'b1, irxc_pkg::CTRL_SET_BASE, 32'h1000);
		fetched(0);
		rd(irxc_pkg::CTRL_SET_BASE, cm, 32'h8400);
		for (int f = 0; f < 2; f++) begin
			for (int k = 0; k < 8; k++) begin
				s = 3'($unsigned($random(seed)) % 3);
				done[0] <= {1'b1, s, 7'(7'h40 >> k)};
				@(posedge clk);
				done[0] <= '0;
				@(posedge clk);
				chk(35'(backout[0]), 35'(f == 1 && k < 3));
				@(posedge clk);
				if (f == 0 || k > 3) rd(irxc_pkg::CTRL_SET_BASE, 32'hFF, {s, ev[k]});
			end
			// Packed mode may only change while stopped; irxc_ctrl still takes set/clear writes to bit 31 while running
			bus(1'b1, irxc_pkg::CTRL_CLR_BASE, 32'h8000);
			bus(1'b1, irxc_pkg::CTRL_SET_BASE, 32'h8000_8000);
			fq.push_back(pv[0]);
			fetched(0);
			chk(35'(packed_fill_mode[0]), 35'h1);
		end
		bus(1'b1, irxc_pkg::CTRL_SET_BASE, 32'h2000_0000);
		rd(irxc_pkg::CTRL_SET_BASE, 32'h2000_0000, 32'h2000_0000);
		cycle_match[0] <= 1'b1;
		@(posedge clk);
		cycle_match[0] <= 1'b0;
		repeat (2) @(posedge clk);
		rd(irxc_pkg::CTRL_SET_BASE, 32'h2000_0000, '0);
		soft_reset <= 1'b1;
		@(posedge clk);
		soft_reset <= 1'b0;
		rd(irxc_pkg::CTRL_SET_BASE, 32'h07FF_FF00, '0);
		complete_run;
	end
	initial begin
		#800000;
		num_errors++;
		complete_run;
	end
endmodule

// ===== verification/irxc_engine.sv
/* Descriptor memory model answering fetch requests.
 Assumes fetch_req stays high until fetch_done is seen. */
`timescale 1ns/10ps
module irxc_engine #(
	parameter int unsigned NCTX = 4
) (
	input logic clk,
	input logic rst_n,
	input logic [3:0] lat,
	input logic [NCTX-1:0] fetch_req,
	output logic [NCTX-1:0] fetch_done
);
	logic [3:0] cnt_r;
	logic [NCTX-1:0] sent_r;
	wire [NCTX-1:0] ask = fetch_req & ~sent_r;
	// One answer per request; lat sets how slow memory is
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
			sent_r <= '0;
			fetch_done <= '0;
		end else begin
			cnt_r <= (ask != '0 && cnt_r != lat) ? cnt_r + 4'h1 : 4'h0;
			fetch_done <= (cnt_r == lat) ? ask : '0;
			sent_r <= fetch_req & (sent_r | ((cnt_r == lat) ? ask : '0));
		end
	end
endmodule

// ===== verification/irxc_props.sv
/* Port assertions for the receive context controller.
 Assumes one clock, async low reset, bound to irxc_ctrl. */
`timescale 1ns/10ps
module irxc_props #(
	parameter int unsigned NCTX = 4
) (
	input logic clk,
	input logic rst_n,
	input logic soft_reset,
	input logic [11:0] avs_address,
	input logic avs_read,
	input logic avs_write,
	input logic [31:0] avs_readdata,
	input logic avs_waitrequest,
	input logic [1:0] avs_response,
	input logic [NCTX-1:0] fetch_req,
	input logic [NCTX-1:0] [31:0] fetch_addr,
	input logic [NCTX-1:0] packed_fill_mode,
	input logic [NCTX-1:0] backout,
	input irxc_pkg::irxc_done_t [NCTX-1:0] done
);
	default clocking dc @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire req = avs_read || avs_write;
	wire ctl = avs_address[11:7] == 5'h08 && avs_address[4:3] == 2'h0;
	wire err = done[0].len_err || done[0].crc_err || done[0].overrun;
	wire bad = done[0].valid && packed_fill_mode[0] && err;
	sequence s_taken;
		req && avs_waitrequest;
	endsequence
	sequence s_answer;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence
	a_bus_answer:
		assert property (s_taken |=> s_answer) else $error("bad answer");
	a_no_spur:
		assert property (!req && avs_waitrequest |=> avs_waitrequest) else $error("spurious");
	a_idle_quiet:
		assert property (avs_waitrequest |-> avs_readdata == '0 && avs_response == '0)
		else $error("bus not quiet");
	a_rsvd_zero:
		assert property (avs_read && !avs_waitrequest && ctl |->
			(avs_readdata & ~irxc_pkg::CTRL_RD_MASK) == '0) else $error("reserved set");
	a_backout_made:
		assert property (bad |=> backout[0]) else $error("no backout");
	a_backout_cause:
		assert property (backout[0] |-> $past(bad)) else $error("stray backout");
	a_ptr_hold:
		assert property ($changed(fetch_addr) |-> $past(avs_write)) else $error("ptr moved");
	a_soft_clear:
		assert property (soft_reset |=> fetch_req == '0) else $error("soft reset");
endmodule
bind irxc_ctrl irxc_props #(.NCTX(NCTX)) u_props (.clk, .rst_n, .soft_reset, .avs_address,
	.avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .avs_response, .fetch_req,
	.fetch_addr, .packed_fill_mode, .backout, .done);
